/* core/alm_limit_monitor.sv */
// alert and limit monitor: limits, hysteresis, min/max recorder, alert status
//
// Contract
// - result flag is set while the read channel or any other channel violates.
// - voltage status holds upper and lower violation bits for four inputs.
// - status bits accumulate; new violations never clear earlier bits.
// - current status bits 3..0 hold current-sense upper and lower violations.
// - current status bits 4 and 5 report the two overrange comparators.
// - temperature status bit 7 flags open diode, bit 6 overtemperature.
// - temperature status bits 5..0 hold violations for three temperature channels.
// - config write with bits 1 and 2 set clears all alert status.
// - writing all ones to a status register clears it to zero.
// - result above upper limit raises the alert.
// - upper alert releases once result is at least N below the limit.
// - result below lower limit raises the alert.
// - lower alert releases once result is at least N above the limit.
// - each channel has its own 12-bit hysteresis register.
// - config write with bits 1 and 2 set also resets the alert pin.
// - hysteresis resets to 8 LSB, or 32 LSB on temperature channels.
// - all-ones hysteresis turns the limits into a min/max recorder.
// - upper limits reset to full scale, lower limits to zero.
// - bit 11 of temperature limit registers reads zero.
// - violations reach the alert pin, the flag, or both, per configuration.
`timescale 1ns/1ps
`default_nettype none

module alm_limit_monitor
    import alm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic conv_valid_in,
    input wire logic [3:0] conv_chan_in,
    input wire logic [11:0] conv_data_in,
    input wire logic current_sense1_overrange_in,
    input wire logic current_sense2_overrange_in,
    input wire logic overtemp_in,
    input wire logic diode_open_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic alert_out,
    output logic alert_flag_out
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else if (ce_in) begin
            pin_meta_q <= {diode_open_in, overtemp_in,
                           current_sense2_overrange_in, current_sense1_overrange_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // register write decode
    // ---------------------------------------------------------------
    logic wr_cfg;
    logic wr_st_volt;
    logic wr_st_cur;
    logic wr_st_temp;
    logic wr_upper;
    logic wr_lower;
    logic wr_hyst;
    logic [3:0] wr_upper_idx;
    logic [3:0] wr_lower_idx;
    logic [3:0] wr_hyst_idx;
    logic cfg_clear;

    assign wr_cfg = reg_wr_in && (reg_addr_in == ALM_ADDR_CONFIG);
    assign wr_st_volt = reg_wr_in && (reg_addr_in == ALM_ADDR_ST_VOLT);
    assign wr_st_cur = reg_wr_in && (reg_addr_in == ALM_ADDR_ST_CUR);
    assign wr_st_temp = reg_wr_in && (reg_addr_in == ALM_ADDR_ST_TEMP);
    assign wr_upper = reg_wr_in && alm_in_bank(reg_addr_in, ALM_ADDR_UPPER_BASE);
    assign wr_lower = reg_wr_in && alm_in_bank(reg_addr_in, ALM_ADDR_LOWER_BASE);
    assign wr_hyst = reg_wr_in && alm_in_bank(reg_addr_in, ALM_ADDR_HYST_BASE);
    assign wr_upper_idx = 4'(reg_addr_in - ALM_ADDR_UPPER_BASE);
    assign wr_lower_idx = 4'(reg_addr_in - ALM_ADDR_LOWER_BASE);
    assign wr_hyst_idx = 4'(reg_addr_in - ALM_ADDR_HYST_BASE);

    // both clear bits in one write act as a one-shot clear
    assign cfg_clear = wr_cfg && reg_wdata_in[ALM_CFG_CLR_A_BIT]
                       && reg_wdata_in[ALM_CFG_CLR_B_BIT];

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    logic [15:0] cfg_q;
    logic pin_en;
    logic flag_en;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_q <= ALM_CFG_RESET;
        end else if (ce_in && wr_cfg) begin
            cfg_q <= reg_wdata_in;
        end
    end

    assign pin_en = cfg_q[ALM_CFG_PIN_EN_BIT];
    assign flag_en = cfg_q[ALM_CFG_FLAG_EN_BIT];

    // ---------------------------------------------------------------
    // limit and hysteresis storage
    // ---------------------------------------------------------------
    logic [11:0] upper_q [ALM_NUM_CH];
    logic [11:0] lower_q [ALM_NUM_CH];
    logic [11:0] hyst_q [ALM_NUM_CH];

    // ---------------------------------------------------------------
    // current conversion and its comparison
    // ---------------------------------------------------------------
    logic conv_ok;
    logic [3:0] ch;
    logic [11:0] cur_upper;
    logic [11:0] cur_lower;
    logic [11:0] cur_hyst;
    logic chk_minmax;
    logic chk_over;
    logic chk_under;
    logic chk_rel_hi;
    logic chk_rel_lo;

    assign conv_ok = conv_valid_in && (conv_chan_in < 4'(ALM_NUM_CH));
    assign ch = conv_ok ? conv_chan_in : 4'h0;
    assign cur_upper = upper_q[ch];
    assign cur_lower = lower_q[ch];
    assign cur_hyst = hyst_q[ch];

    alm_limit_check u_check (
        .data_in(conv_data_in),
        .upper_in(cur_upper),
        .lower_in(cur_lower),
        .hyst_in(cur_hyst),
        .minmax_out(chk_minmax),
        .over_out(chk_over),
        .under_out(chk_under),
        .release_hi_out(chk_rel_hi),
        .release_lo_out(chk_rel_lo)
    );

    // host writes take the register; otherwise min/max mode may move it
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < ALM_NUM_CH; i++) begin
                upper_q[i] <= alm_mask_limit(4'(i), ALM_UPPER_RESET);
                lower_q[i] <= ALM_LOWER_RESET;
            end
        end else if (ce_in) begin
            if (conv_ok && chk_minmax && chk_over) begin
                upper_q[ch] <= alm_mask_limit(ch, conv_data_in);
            end
            if (wr_upper) begin
                upper_q[wr_upper_idx] <= alm_mask_limit(wr_upper_idx,
                                                        reg_wdata_in[11:0]);
            end
            if (conv_ok && chk_minmax && chk_under) begin
                lower_q[ch] <= alm_mask_limit(ch, conv_data_in);
            end
            if (wr_lower) begin
                lower_q[wr_lower_idx] <= alm_mask_limit(wr_lower_idx,
                                                        reg_wdata_in[11:0]);
            end
        end
    end

    // one hysteresis word per limit pair
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < ALM_NUM_CH; i++) begin
                hyst_q[i] <= alm_is_temp(4'(i)) ? ALM_HYST_RESET_TEMP
                                                : ALM_HYST_RESET_GEN;
            end
        end else if (ce_in && wr_hyst) begin
            hyst_q[wr_hyst_idx] <= reg_wdata_in[11:0];
        end
    end

    // ---------------------------------------------------------------
    // active violation state
    // ---------------------------------------------------------------
    logic [ALM_NUM_CH-1:0] act_hi_q;
    logic [ALM_NUM_CH-1:0] act_lo_q;
    logic [ALM_NUM_CH-1:0] act_hi_d;
    logic [ALM_NUM_CH-1:0] act_lo_d;
    logic [2*ALM_NUM_CH-1:0] evt;

    // evt holds lower violation at 2*ch and upper violation at 2*ch+1
    always_comb begin
        act_hi_d = act_hi_q;
        act_lo_d = act_lo_q;
        evt = '0;
        if (cfg_clear) begin
            act_hi_d = '0;
            act_lo_d = '0;
        end
        if (conv_ok) begin
            if (chk_minmax) begin
                act_hi_d[ch] = 1'b0;
                act_lo_d[ch] = 1'b0;
            end else begin
                if (chk_over) begin
                    act_hi_d[ch] = 1'b1;
                    evt[{ch, 1'b1}] = 1'b1;
                end else if (chk_rel_hi) begin
                    act_hi_d[ch] = 1'b0;
                end
                if (chk_under) begin
                    act_lo_d[ch] = 1'b1;
                    evt[{ch, 1'b0}] = 1'b1;
                end else if (chk_rel_lo) begin
                    act_lo_d[ch] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            act_hi_q <= '0;
            act_lo_q <= '0;
        end else if (ce_in) begin
            act_hi_q <= act_hi_d;
            act_lo_q <= act_lo_d;
        end
    end

    // ---------------------------------------------------------------
    // alert pin and result flag
    // ---------------------------------------------------------------
    logic any_active_d;

    assign any_active_d = (|act_hi_d) || (|act_lo_d);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            alert_out <= 1'b0;
            alert_flag_out <= 1'b0;
        end else if (ce_in) begin
            alert_out <= pin_en && any_active_d;
            alert_flag_out <= flag_en && any_active_d;
        end
    end

    // ---------------------------------------------------------------
    // alert status registers
    // ---------------------------------------------------------------
    logic [7:0] st_volt_q;
    logic [7:0] st_cur_q;
    logic [7:0] st_temp_q;
    logic [7:0] set_volt;
    logic [7:0] set_cur;
    logic [7:0] set_temp;

    assign set_volt = evt[7:0];
    assign set_cur = {2'b00, pin_sync_q[1], pin_sync_q[0], evt[11:8]};
    assign set_temp = {pin_sync_q[3], pin_sync_q[2], evt[17:12]};

    // new events are ORed after any clear, so a same-cycle event survives
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_volt_q <= ALM_ST_RESET;
            st_cur_q <= ALM_ST_RESET;
            st_temp_q <= ALM_ST_RESET;
        end else if (ce_in) begin
            st_volt_q <= alm_status_next(st_volt_q, wr_st_volt, reg_wdata_in[7:0],
                                         cfg_clear, set_volt);
            st_cur_q <= alm_status_next(st_cur_q, wr_st_cur, reg_wdata_in[7:0],
                                        cfg_clear, set_cur);
            st_temp_q <= alm_status_next(st_temp_q, wr_st_temp, reg_wdata_in[7:0],
                                         cfg_clear, set_temp);
        end
    end

    // ---------------------------------------------------------------
    // last conversion result
    // ---------------------------------------------------------------
    logic [3:0] res_chan_q;
    logic [11:0] res_data_q;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            res_chan_q <= 4'h0;
            res_data_q <= 12'h000;
        end else if (ce_in && conv_ok) begin
            res_chan_q <= ch;
            res_data_q <= conv_data_in;
        end
    end

    // ---------------------------------------------------------------
    // register read
    // ---------------------------------------------------------------
    logic [15:0] rd_word;
    logic [3:0] rd_upper_idx;
    logic [3:0] rd_lower_idx;
    logic [3:0] rd_hyst_idx;

    assign rd_upper_idx = 4'(reg_addr_in - ALM_ADDR_UPPER_BASE);
    assign rd_lower_idx = 4'(reg_addr_in - ALM_ADDR_LOWER_BASE);
    assign rd_hyst_idx = 4'(reg_addr_in - ALM_ADDR_HYST_BASE);

    always_comb begin
        rd_word = 16'h0000;
        if (reg_addr_in == ALM_ADDR_RESULT) begin
            rd_word = {alert_flag_out, res_chan_q[2:0], res_data_q};
        end else if (reg_addr_in == ALM_ADDR_CONFIG) begin
            rd_word = cfg_q;
        end else if (reg_addr_in == ALM_ADDR_ST_VOLT) begin
            rd_word = {8'h00, st_volt_q};
        end else if (reg_addr_in == ALM_ADDR_ST_CUR) begin
            rd_word = {8'h00, st_cur_q};
        end else if (reg_addr_in == ALM_ADDR_ST_TEMP) begin
            rd_word = {8'h00, st_temp_q};
        end else if (alm_in_bank(reg_addr_in, ALM_ADDR_UPPER_BASE)) begin
            rd_word = {4'h0, upper_q[rd_upper_idx]};
        end else if (alm_in_bank(reg_addr_in, ALM_ADDR_LOWER_BASE)) begin
            rd_word = {4'h0, lower_q[rd_lower_idx]};
        end else if (alm_in_bank(reg_addr_in, ALM_ADDR_HYST_BASE)) begin
            rd_word = {4'h0, hyst_q[rd_hyst_idx]};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else if (ce_in) begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rd_word;
            end
        end
    end

endmodule

`default_nettype wire

/* common/alm_pkg.sv */
// package: constants, register map and helpers of the alert and limit monitor
package alm_pkg;

    // ---------------------------------------------------------------
    // channel layout
    // ---------------------------------------------------------------
    localparam int ALM_NUM_CH = 9;
    localparam int ALM_DATA_W = 12;
    localparam int ALM_REG_W = 16;
    localparam int ALM_ADDR_W = 8;
    localparam int ALM_ST_W = 8;
    localparam logic [3:0] ALM_CH_CUR_FIRST = 4'h4;
    localparam logic [3:0] ALM_CH_TEMP_FIRST = 4'h6;

    // ---------------------------------------------------------------
    // register pointers
    // ---------------------------------------------------------------
    localparam logic [7:0] ALM_ADDR_RESULT = 8'h01;
    localparam logic [7:0] ALM_ADDR_ST_VOLT = 8'h04;
    localparam logic [7:0] ALM_ADDR_ST_CUR = 8'h05;
    localparam logic [7:0] ALM_ADDR_ST_TEMP = 8'h06;
    localparam logic [7:0] ALM_ADDR_CONFIG = 8'h09;
    localparam logic [7:0] ALM_ADDR_UPPER_BASE = 8'h10;
    localparam logic [7:0] ALM_ADDR_LOWER_BASE = 8'h20;
    localparam logic [7:0] ALM_ADDR_HYST_BASE = 8'h30;

    // ---------------------------------------------------------------
    // configuration fields
    // ---------------------------------------------------------------
    localparam int ALM_CFG_CLR_A_BIT = 1;
    localparam int ALM_CFG_CLR_B_BIT = 2;
    localparam int ALM_CFG_PIN_EN_BIT = 3;
    localparam int ALM_CFG_FLAG_EN_BIT = 4;
    localparam logic [15:0] ALM_CFG_RESET = 16'h0018;

    // ---------------------------------------------------------------
    // status fields and result word
    // ---------------------------------------------------------------
    localparam int ALM_ST_OVR1_BIT = 4;
    localparam int ALM_ST_OVR2_BIT = 5;
    localparam int ALM_ST_OVERTEMP_BIT = 6;
    localparam int ALM_ST_DIODE_OPEN_BIT = 7;
    localparam logic [7:0] ALM_ST_ALL_ONES = 8'hFF;
    localparam logic [7:0] ALM_ST_RESET = 8'h00;
    localparam int ALM_RES_FLAG_BIT = 15;
    localparam int ALM_TEMP_OPEN_BIT = 11;

    // ---------------------------------------------------------------
    // reset values of limits and hysteresis
    // ---------------------------------------------------------------
    localparam logic [11:0] ALM_UPPER_RESET = 12'hFFF;
    localparam logic [11:0] ALM_LOWER_RESET = 12'h000;
    localparam logic [11:0] ALM_HYST_RESET_GEN = 12'h008;
    localparam logic [11:0] ALM_HYST_RESET_TEMP = 12'h020;
    localparam logic [11:0] ALM_HYST_MINMAX = 12'hFFF;

    // pointer falls inside a bank of per-channel registers
    function automatic logic alm_in_bank(input logic [7:0] addr, input logic [7:0] base);
        alm_in_bank = (addr >= base) && (addr < base + 8'(ALM_NUM_CH));
    endfunction

    function automatic logic alm_is_temp(input logic [3:0] ch);
        alm_is_temp = (ch >= ALM_CH_TEMP_FIRST);
    endfunction

    // temperature limits keep the open-diode position at zero
    function automatic logic [11:0] alm_mask_limit(input logic [3:0] ch, input logic [11:0] v);
        logic [11:0] r;
        r = v;
        if (alm_is_temp(ch)) begin
            r[ALM_TEMP_OPEN_BIT] = 1'b0;
        end
        alm_mask_limit = r;
    endfunction

    // sticky status: write, all-ones clear, global clear, then new events win
    function automatic logic [7:0] alm_status_next(input logic [7:0] q, input logic wr,
                                                   input logic [7:0] wd, input logic clr,
                                                   input logic [7:0] set);
        logic [7:0] r;
        r = q;
        if (wr) begin
            r = (wd == ALM_ST_ALL_ONES) ? ALM_ST_RESET : wd;
        end else if (clr) begin
            r = ALM_ST_RESET;
        end
        alm_status_next = r | set;
    endfunction

endpackage

/* core/alm_limit_check.sv */
// limit comparison with hysteresis and min/max mode detection for one result
`timescale 1ns/1ps
`default_nettype none

module alm_limit_check
    import alm_pkg::*;
(
    input wire logic [11:0] data_in,
    input wire logic [11:0] upper_in,
    input wire logic [11:0] lower_in,
    input wire logic [11:0] hyst_in,
    output logic minmax_out,
    output logic over_out,
    output logic under_out,
    output logic release_hi_out,
    output logic release_lo_out
);
    logic [12:0] data_plus_hyst;
    logic [12:0] lower_plus_hyst;

    // sums carry one extra bit so a large hysteresis never wraps
    assign data_plus_hyst = {1'b0, data_in} + {1'b0, hyst_in};
    assign lower_plus_hyst = {1'b0, lower_in} + {1'b0, hyst_in};

    assign minmax_out = (hyst_in == ALM_HYST_MINMAX);
    assign over_out = (data_in > upper_in);
    assign under_out = (data_in < lower_in);
    assign release_hi_out = (data_plus_hyst <= {1'b0, upper_in});
    assign release_lo_out = ({1'b0, data_in} >= lower_plus_hyst);

endmodule

`default_nettype wire

/* tb/alm_limit_monitor_sva.sv */
// checker: port-level assertions of the alert and limit monitor
`timescale 1ns/1ps
`default_nettype none

module alm_limit_monitor_sva
    import alm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic conv_valid_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic alert_out,
    input wire logic alert_flag_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // ----
    // helpers
    // ----
    logic rd, wr, act, seen_q, act_q;
    assign rd = ce_in && reg_rd_in;
    assign wr = ce_in && reg_wr_in;
    assign act = ce_in && (conv_valid_in || reg_wr_in);
    // reset-value checks hold only until the first write
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            seen_q <= 1'b0;
        end else if (wr) begin
            seen_q <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        act_q <= !rst_in && act;
    end

    // ----
    // checks
    // ----
    chk_read_answer: assert property (rd |=> reg_rvalid_out) else $error("read not answered");
    chk_status_width: assert property (rd && reg_addr_in inside {[8'h04:8'h06]}
        |=> reg_rdata_out[15:8] == 8'h00) else $error("status upper byte set");
    chk_temp_bit11: assert property (rd && reg_addr_in[3:0] inside {[4'h6:4'h8]}
        && reg_addr_in[7:4] inside {4'h1, 4'h2} |=> !reg_rdata_out[11])
        else $error("temperature limit bit 11 set");
    chk_hyst_default: assert property (!seen_q && rd && reg_addr_in == 8'h30
        |=> reg_rdata_out == 16'h0008) else $error("hysteresis default wrong");
    chk_upper_default: assert property (!seen_q && rd && reg_addr_in == 8'h16
        |=> reg_rdata_out == 16'h07FF) else $error("upper limit default wrong");
    chk_allones_clear: assert property (wr && reg_addr_in == ALM_ADDR_ST_VOLT
        && reg_wdata_in[7:0] == 8'hFF && !conv_valid_in ##1 !act
        ##1 rd && reg_addr_in == ALM_ADDR_ST_VOLT |=> reg_rdata_out == 16'h0000)
        else $error("all-ones write kept status");
    chk_clear_alert: assert property (wr && reg_addr_in == ALM_ADDR_CONFIG
        && reg_wdata_in[2:1] == 2'b11 && !conv_valid_in ##1 ce_in && !conv_valid_in
        |=> !alert_out && !alert_flag_out) else $error("clear left alert active");
    chk_alert_cause: assert property ($rose(alert_out) |-> act_q || $past(act_q))
        else $error("alert rose without cause");
    chk_flag_cause: assert property ($rose(alert_flag_out) |-> act_q || $past(act_q))
        else $error("flag rose without cause");
    chk_alert_release: assert property ($fell(alert_out) |-> act_q || $past(act_q))
        else $error("alert fell without cause");
endmodule

bind alm_limit_monitor alm_limit_monitor_sva u_sva (.sys_clk_in, .rst_in, .ce_in, .conv_valid_in,
    .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
    .alert_out, .alert_flag_out);
`default_nettype wire

/* tb/alm_host_model.sv */
// host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none

module alm_host_model
    import alm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic [15:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [15:0] reg_wdata_out
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 16'h0000;
    end
    // ----
    // access tasks; released lines show the inverse of the last request
    // ----
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_wr_out <= 1'b1;
        reg_addr_out <= a;
        reg_wdata_out <= d;
        @(posedge sys_clk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(posedge sys_clk_in);
        reg_rd_out <= 1'b1;
        reg_addr_out <= a;
        @(posedge sys_clk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        for (int i = 0; i < 3 && !ok; i++) begin
            #1;
            if (reg_rvalid_in === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata_in;
            end else begin
                @(posedge sys_clk_in);
            end
        end
    endtask
    // clears overrange faults raised while supplies come up
    task automatic init();
        wr(ALM_ADDR_ST_CUR, 16'h0000);
    endtask
endmodule
`default_nettype wire

/* tb/alm_limit_monitor_tb_top.sv */
// self-checking bench of the alert and limit monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) cmp(16'(g), 16'(e))

module alm_limit_monitor_tb_top
    import alm_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic conv_valid_in = 1'b0;
    logic [3:0] conv_chan_in = 4'h0;
    logic [11:0] conv_data_in = 12'h000;
    logic current_sense1_overrange_in = 1'b0;
    logic current_sense2_overrange_in = 1'b0;
    logic overtemp_in = 1'b0;
    logic diode_open_in = 1'b0;
    logic reg_wr_in, reg_rd_in, reg_rvalid_out, alert_out, alert_flag_out;
    logic [7:0] reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    int n_mismatch = 0;
    int checks_done = 0;

    initial forever #2.5 sys_clk_in = ~sys_clk_in;

    alm_limit_monitor DUT (.sys_clk_in, .rst_in, .ce_in, .conv_valid_in, .conv_chan_in,
        .conv_data_in, .current_sense1_overrange_in, .current_sense2_overrange_in, .overtemp_in,
        .diode_open_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
        .reg_rvalid_out, .alert_out, .alert_flag_out);
    alm_host_model host (.sys_clk_in, .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out),
        .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in),
        .reg_wdata_out(reg_wdata_in));

    // ----
    // helpers
    // ----
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        host.rd(a, d, ok);
        if (!ok) begin
            n_mismatch++;
            wrap_up();
        end
        `CHK(d, e);
    endtask
    task automatic conv(input logic [3:0] ch, input logic [11:0] d);
        @(posedge sys_clk_in);
        conv_valid_in <= 1'b1;
        conv_chan_in <= ch;
        conv_data_in <= d;
        @(posedge sys_clk_in);
        conv_valid_in <= 1'b0;
        conv_data_in <= ~d;
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // ----
    // sequence
    // ----
    initial begin
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (int c = 0; c < 9; c++) begin
            rdc(ALM_ADDR_HYST_BASE + 8'(c), (c >= 6) ? 16'h0020 : 16'h0008);
            rdc(ALM_ADDR_UPPER_BASE + 8'(c), (c >= 6) ? 16'h07FF : 16'h0FFF);
            rdc(ALM_ADDR_LOWER_BASE + 8'(c), 16'h0000);
        end
        rdc(ALM_ADDR_CONFIG, 16'h0018);
        host.wr(8'hFF, 16'h1234);
        rdc(8'hFF, 16'h0000);
        host.init();
        host.wr(ALM_ADDR_UPPER_BASE, 16'h0800);
        conv(4'h0, 12'h800);
        `CHK(alert_out, 1'b0);
        conv(4'h0, 12'h801);
        `CHK({alert_out, alert_flag_out}, 2'b11);
        conv(4'h0, 12'h7F9);
        `CHK(alert_out, 1'b1);
        conv(4'h2, 12'h500);
        rdc(ALM_ADDR_RESULT, 16'hA500);
        conv(4'h0, 12'h7F8);
        `CHK({alert_out, alert_flag_out}, 2'b00);
        host.wr(ALM_ADDR_HYST_BASE + 8'h01, 16'h0010);
        host.wr(ALM_ADDR_LOWER_BASE + 8'h01, 16'h0100);
        conv(4'h1, 12'h0FF);
        `CHK(alert_out, 1'b1);
        rdc(ALM_ADDR_ST_VOLT, 16'h0006);
        conv(4'h1, 12'h10F);
        `CHK(alert_out, 1'b1);
        conv(4'h1, 12'h110);
        `CHK(alert_out, 1'b0);
        host.wr(ALM_ADDR_ST_VOLT, 16'h00FF);
        rdc(ALM_ADDR_ST_VOLT, 16'h0000);
        host.wr(ALM_ADDR_UPPER_BASE + 8'h05, 16'h0400);
        conv(4'h5, 12'h401);
        rdc(ALM_ADDR_ST_CUR, 16'h0008);
        @(posedge sys_clk_in) current_sense1_overrange_in <= 1'b1;
        tick(5);
        rdc(ALM_ADDR_ST_CUR, 16'h0018);
        @(posedge sys_clk_in) current_sense2_overrange_in <= 1'b1;
        tick(5);
        rdc(ALM_ADDR_ST_CUR, 16'h0038);
        host.wr(ALM_ADDR_LOWER_BASE + 8'h08, 16'h0050);
        conv(4'h8, 12'h040);
        @(posedge sys_clk_in) {overtemp_in, diode_open_in, current_sense1_overrange_in,
            current_sense2_overrange_in} <= 4'hC;
        tick(5);
        rdc(ALM_ADDR_ST_TEMP, 16'h00D0);
        @(posedge sys_clk_in) {overtemp_in, diode_open_in} <= 2'b00;
        tick(5);
        host.init();
        rdc(ALM_ADDR_ST_CUR, 16'h0000);
        host.wr(ALM_ADDR_UPPER_BASE + 8'h06, 16'h0FFF);
        rdc(ALM_ADDR_UPPER_BASE + 8'h06, 16'h07FF);
        `CHK(alert_out, 1'b1);
        host.wr(ALM_ADDR_CONFIG, 16'h001E);
        tick(1);
        `CHK({alert_out, alert_flag_out}, 2'b00);
        for (int a = 0; a < 3; a++) rdc(ALM_ADDR_ST_VOLT + 8'(a), 16'h0000);
        host.wr(ALM_ADDR_CONFIG, 16'h0008);
        conv(4'h0, 12'h900);
        `CHK({alert_out, alert_flag_out}, 2'b10);
        host.wr(ALM_ADDR_CONFIG, 16'h0010);
        tick(1);
        `CHK({alert_out, alert_flag_out}, 2'b01);
        @(posedge sys_clk_in) ce_in <= 1'b0;
        conv(4'h0, 12'h100);
        `CHK(alert_flag_out, 1'b1);
        @(posedge sys_clk_in) ce_in <= 1'b1;
        host.wr(ALM_ADDR_CONFIG, 16'h001E);
        host.wr(ALM_ADDR_HYST_BASE + 8'h03, 16'h0FFF);
        host.wr(ALM_ADDR_UPPER_BASE + 8'h03, 16'h0100);
        host.wr(ALM_ADDR_LOWER_BASE + 8'h03, 16'h0200);
        conv(4'h3, 12'h180);
        conv(4'h3, 12'h300);
        `CHK(alert_out, 1'b0);
        rdc(ALM_ADDR_UPPER_BASE + 8'h03, 16'h0300);
        rdc(ALM_ADDR_LOWER_BASE + 8'h03, 16'h0180);
        rdc(ALM_ADDR_ST_VOLT, 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
